// ==== include/aecp_pkg.sv ====
// Constants shared by the asynchronous event counter pair.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz system clock.
package aecp_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] AECP_OFS_CLKSTOP = 8'h00;
    localparam logic [7:0] AECP_OFS_CTRL    = 8'h04;
    localparam logic [7:0] AECP_OFS_CLEAR   = 8'h08;
    localparam logic [7:0] AECP_OFS_CNTLOW  = 8'h0C;
    localparam logic [7:0] AECP_OFS_CNTHIGH = 8'h10;

    // Values after reset.
    localparam logic [7:0] AECP_RST_CLKSTOP = 8'hFF;
    localparam logic [4:0] AECP_RST_CTRL    = 5'h00;
    localparam logic [7:0] AECP_RST_COUNT   = 8'h00;

    // Field positions.
    localparam int AECP_BIT_RUN      = 3;
    localparam int AECP_POS_SRCLOW   = 0;
    localparam int AECP_POS_SRCHIGH  = 2;
    localparam int AECP_BIT_CASCADE  = 4;
    localparam int AECP_BIT_CLRLOW   = 0;
    localparam int AECP_BIT_CLRHIGH  = 1;

    // Count source selection codes.
    localparam logic [1:0] AECP_SRC_PIN  = 2'h0;
    localparam logic [1:0] AECP_SRC_DIV2 = 2'h1;
    localparam logic [1:0] AECP_SRC_DIV4 = 2'h2;
    localparam logic [1:0] AECP_SRC_DIV8 = 2'h3;

    // Prescaler terminal counts for the divided clocks.
    localparam logic [2:0] AECP_DIV2_END = 3'h1;
    localparam logic [2:0] AECP_DIV4_END = 3'h3;
    localparam logic [2:0] AECP_DIV8_END = 3'h7;

    // Bus responses.
    localparam logic [1:0] AECP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AECP_RESP_SLVERR = 2'h2;

endpackage : aecp_pkg

// ==== hw/aecp_counter.sv ====
// Asynchronous event counter pair with an AXI4-Lite register slave.
// Assumes event pins are asynchronous and need two flip-flops of
// synchronisation; everything else runs on sys_clk.
//
// Contract
// - High counter: 8-bit, standalone or upper byte.
// - High source: pin, clock/2/4/8, low overflow.
// - High counter zero on reset or clear.
// - Low counter: 8-bit, standalone or lower byte.
// - Low source: pin or clock/2/4/8.
// - Low counter zero on reset or clear.
// - Standby bit 3: zero stops, resets one.
`timescale 1ns/10ps
module aecp_counter
    import aecp_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Event pins.
    input  wire logic        async_event_in_low,
    input  wire logic        async_event_in_high,
    // AXI4-Lite write address and data.
    input  wire logic        s_axi_awvalid,
    output wire logic        s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output wire logic        s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response.
    output wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output wire logic [1:0]  s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic        s_axi_arvalid,
    output wire logic        s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output wire logic [31:0] s_axi_rdata,
    output wire logic [1:0]  s_axi_rresp
);

    logic [7:0]  clkStop_ff;
    logic [4:0]  ctrl_ff;
    logic [7:0]  cntLow_ff;
    logic [7:0]  cntHigh_ff;
    logic [2:0]  presc_ff;
    logic [1:0]  sync1_ff;
    logic [1:0]  sync2_ff;
    logic [1:0]  prev_ff;
    logic        awHeld_ff;
    logic        wHeld_ff;
    logic [7:0]  awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0]  wStrb_ff;
    logic        bValid_ff;
    logic [1:0]  bResp_ff;
    logic        rValid_ff;
    logic [31:0] rData_ff;
    logic [1:0]  rResp_ff;

    // Decoded control fields.
    wire        eventRun = clkStop_ff[AECP_BIT_RUN];
    wire        cascade  = ctrl_ff[AECP_BIT_CASCADE];
    wire [1:0]  srcLow   = ctrl_ff[AECP_POS_SRCLOW +: 2];
    wire [1:0]  srcHigh  = ctrl_ff[AECP_POS_SRCHIGH +: 2];
    wire [1:0]  srcSel [2];
    wire [1:0]  pinEdge;
    wire [1:0]  tick;

    assign srcSel[0] = srcLow;
    assign srcSel[1] = srcHigh;

    // Prescaler strobes; the prescaler only runs while not in standby.
    wire div2Tick = (presc_ff[0] == AECP_DIV2_END[0]);
    wire div4Tick = (presc_ff[1:0] == AECP_DIV4_END[1:0]);
    wire div8Tick = (presc_ff == AECP_DIV8_END);

    // Per-channel pin synchroniser, rising-edge detector and source mux.
    // Only the second stage feeds the edge detector, never the first.
    wire [1:0] pinRaw = {async_event_in_high, async_event_in_low};
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    sync1_ff[ch] <= 1'b0;
                    sync2_ff[ch] <= 1'b0;
                    prev_ff[ch]  <= 1'b0;
                end else begin
                    sync1_ff[ch] <= pinRaw[ch];
                    sync2_ff[ch] <= sync1_ff[ch];
                    prev_ff[ch]  <= sync2_ff[ch];
                end
            end
            assign pinEdge[ch] = sync2_ff[ch] & ~prev_ff[ch];
            assign tick[ch] = (srcSel[ch] == AECP_SRC_PIN)  ? pinEdge[ch] :
                              (srcSel[ch] == AECP_SRC_DIV2) ? div2Tick :
                              (srcSel[ch] == AECP_SRC_DIV4) ? div4Tick :
                                                              div8Tick;
        end
    endgenerate

    // Count enables; the low overflow clocks the high byte in cascade.
    wire lowTick  = eventRun & tick[0];
    wire lowOvf   = lowTick & (cntLow_ff == 8'hFF);
    wire highTick = eventRun & (cascade ? lowOvf : tick[1]);

    // Bus write decode, done once both address and data are held.
    wire doWrite  = awHeld_ff & wHeld_ff & ~bValid_ff;
    wire wrHit    = (awAddr_ff == AECP_OFS_CLKSTOP) |
                    (awAddr_ff == AECP_OFS_CTRL) |
                    (awAddr_ff == AECP_OFS_CLEAR);
    wire wrStop   = doWrite & wStrb_ff[0] & (awAddr_ff == AECP_OFS_CLKSTOP);
    wire wrCtrl   = doWrite & wStrb_ff[0] & (awAddr_ff == AECP_OFS_CTRL);
    wire wrClear  = doWrite & wStrb_ff[0] & (awAddr_ff == AECP_OFS_CLEAR);
    wire clrLow   = wrClear & wData_ff[AECP_BIT_CLRLOW];
    wire clrHigh  = wrClear & wData_ff[AECP_BIT_CLRHIGH];

    // Bus read decode; counters are read-only and the clear strobes read as zero.
    wire [7:0] rdAddr = s_axi_araddr;
    wire       rdHit  = (rdAddr == AECP_OFS_CLKSTOP) |
                        (rdAddr == AECP_OFS_CTRL) |
                        (rdAddr == AECP_OFS_CLEAR) |
                        (rdAddr == AECP_OFS_CNTLOW) |
                        (rdAddr == AECP_OFS_CNTHIGH);
    wire [7:0] rdByte =
        (rdAddr == AECP_OFS_CLKSTOP) ? clkStop_ff :
        (rdAddr == AECP_OFS_CTRL)    ? {3'h0, ctrl_ff} :
        (rdAddr == AECP_OFS_CNTLOW)  ? cntLow_ff :
        (rdAddr == AECP_OFS_CNTHIGH) ? cntHigh_ff : 8'h00;

    // Handshake outputs.
    assign s_axi_awready = ~awHeld_ff & ~bValid_ff;
    assign s_axi_wready  = ~wHeld_ff & ~bValid_ff;
    assign s_axi_bvalid  = bValid_ff;
    assign s_axi_bresp   = bResp_ff;
    assign s_axi_arready = ~rValid_ff;
    assign s_axi_rvalid  = rValid_ff;
    assign s_axi_rdata   = rData_ff;
    assign s_axi_rresp   = rResp_ff;

    // Prescaler is held at zero in standby so divided sources stop with the block.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !eventRun) begin
            presc_ff <= 3'h0;
        end else begin
            presc_ff <= presc_ff + 3'h1;
        end
    end

    // Low counter; a software clear beats a coincident count.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || clrLow) begin
            cntLow_ff <= AECP_RST_COUNT;
        end else if (lowTick) begin
            cntLow_ff <= cntLow_ff + 8'h01;
        end
    end

    // High counter, standalone or upper byte of the 16-bit pair.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || clrHigh) begin
            cntHigh_ff <= AECP_RST_COUNT;
        end else if (highTick) begin
            cntHigh_ff <= cntHigh_ff + 8'h01;
        end
    end

    // Software settings; standby bit comes out of reset released.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clkStop_ff <= AECP_RST_CLKSTOP;
            ctrl_ff    <= AECP_RST_CTRL;
        end else begin
            if (wrStop) begin
                clkStop_ff <= wData_ff[7:0];
            end
            if (wrCtrl) begin
                ctrl_ff <= wData_ff[4:0];
            end
        end
    end

    // Write channel: address and data are taken in either order.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff  <= 32'h0000_0000;
            wStrb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_ff <= 1'b0;
            end
        end
    end

    // Write response, one cycle after both halves are held.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bValid_ff <= 1'b0;
            bResp_ff  <= AECP_RESP_OKAY;
        end else if (doWrite) begin
            bValid_ff <= 1'b1;
            bResp_ff  <= wrHit ? AECP_RESP_OKAY : AECP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_ff <= 1'b0;
        end
    end

    // Read channel: data registered on the address handshake.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rValid_ff <= 1'b0;
            rData_ff  <= 32'h0000_0000;
            rResp_ff  <= AECP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_ff <= 1'b1;
            rData_ff  <= {24'h000000, rdByte};
            rResp_ff  <= rdHit ? AECP_RESP_OKAY : AECP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rValid_ff <= 1'b0;
        end
    end

    // Checks on counting, clearing, standby and register writes.
    AST_HIGH_CASCADE: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (cascade && eventRun && lowOvf && !clrHigh)
        |=> (cntHigh_ff == 8'($past(cntHigh_ff) + 8'h01)) && cntLow_ff == 8'h00)
        else $error("High byte did not follow low overflow.");

    AST_HIGH_HOLD: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (!cascade && !tick[1] && !clrHigh) |=> $stable(cntHigh_ff))
        else $error("High counter moved without a source tick.");

    AST_HIGH_CLR: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        clrHigh |=> cntHigh_ff == 8'h00)
        else $error("High counter not cleared.");

    AST_LOW_COUNT: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (lowTick && !clrLow)
        |=> cntLow_ff == 8'($past(cntLow_ff) + 8'h01))
        else $error("Low counter missed a count.");

    AST_LOW_DIV8: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (srcLow == AECP_SRC_DIV8 && eventRun && !wrCtrl && !wrStop
            && !clrLow && lowTick)
        |=> (!lowTick || srcLow != AECP_SRC_DIV8) [*7])
        else $error("Divide-by-8 source ticked too often.");

    AST_LOW_CLR: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        clrLow |=> cntLow_ff == 8'h00)
        else $error("Low counter not cleared.");

    AST_STANDBY: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (!eventRun && !clrLow && !clrHigh)
        |=> $stable(cntLow_ff) && $stable(cntHigh_ff))
        else $error("Counters moved in module standby.");

    AST_CTRL_WRITE: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        wrCtrl |=> ctrl_ff == $past(wData_ff[4:0]) && s_axi_bvalid)
        else $error("Control write not stored or not answered.");

endmodule : aecp_counter

// ==== verification/aecp_event_src.sv ====
// Behavioural model of the two event sources that feed the counter pins.
// Assumes requests arrive as one-cycle pulses on the system clock.
`timescale 1ns/10ps
module aecp_event_src (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Pulse requests from the bench.
    input  wire logic reqLow,
    input  wire logic reqHigh,
    // Event pins.
    output wire logic pinLow,
    output wire logic pinHigh
);
    logic [2:0] phaseLow_ff;
    logic [2:0] phaseHigh_ff;

    // Each pulse is high three cycles then low three, above the 80 ns floor.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phaseLow_ff  <= 3'h0;
            phaseHigh_ff <= 3'h0;
        end else begin
            if (phaseLow_ff != 3'h0) phaseLow_ff <= phaseLow_ff - 3'h1;
            else if (reqLow) phaseLow_ff <= 3'h6;
            if (phaseHigh_ff != 3'h0) phaseHigh_ff <= phaseHigh_ff - 3'h1;
            else if (reqHigh) phaseHigh_ff <= 3'h6;
        end
    end

    // Pins rest low outside pulses.
    assign pinLow  = (phaseLow_ff > 3'h3);
    assign pinHigh = (phaseHigh_ff > 3'h3);
endmodule : aecp_event_src

// ==== verification/testbench.sv ====
// Self-checking bench for the event counter pair.
// Assumes the register map of aecp_pkg and the event source model.
`timescale 1ns/10ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    import aecp_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, reqLow = 1'b0, reqHigh = 1'b0;
    logic evLow, evHigh, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fails = 0;
    int checksDone = 0;

    // Device under test and its event sources.
    aecp_counter aecp_counter_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .async_event_in_low(evLow), .async_event_in_high(evHigh),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp));
    aecp_event_src aecp_event_src_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reqLow(reqLow), .reqHigh(reqHigh), .pinLow(evLow),
        .pinHigh(evHigh));

    // A 40 ns system clock.
    always #20 sys_clk = ~sys_clk;

    // Prints the counts and the verdict, then stops the run.
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    // Full-word write; address and data are released as each is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, AECP_RESP_OKAY)
        // One idle edge so a following call never re-drives bready at once.
        @(posedge sys_clk);
    endtask : wr

    // Read; data and response are taken at the edge with rvalid high.
    task automatic rdRaw(input logic [7:0] a, output logic [33:0] dr);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        dr = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        // One idle edge so a following call never re-drives rready at once.
        @(posedge sys_clk);
    endtask : rdRaw

    // Register read that expects OKAY and zero upper bits.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        logic [33:0] dr;
        rdRaw(a, dr);
        v = dr[9:2];
        `CHK({dr[33:10], dr[1:0]}, {24'h0, AECP_RESP_OKAY})
    endtask : rd

    function automatic logic inRange(logic [7:0] v, int lo, int hi);
        return (v >= lo) && (v <= hi);
    endfunction : inRange

    // One event pulse on the chosen pin, then enough time to count it.
    task automatic pulse(input bit high);
        if (high) reqHigh <= 1'b1;
        else reqLow <= 1'b1;
        @(posedge sys_clk);
        reqLow <= 1'b0; reqHigh <= 1'b0;
        repeat (10) @(posedge sys_clk);
    endtask : pulse

    task automatic testReset;
        logic [7:0] v;
        logic [33:0] dr;
        `CHK({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h7)
        `CHK({s_axi_bvalid, s_axi_rvalid}, 2'h0)
        rd(AECP_OFS_CLKSTOP, v); `CHK(v, AECP_RST_CLKSTOP)
        rd(AECP_OFS_CNTLOW, v); `CHK(v, AECP_RST_COUNT)
        rd(AECP_OFS_CNTHIGH, v); `CHK(v, AECP_RST_COUNT)
        rdRaw(8'h14, dr); `CHK(dr, {32'h0, AECP_RESP_SLVERR})
    endtask : testReset

    task automatic testPinsAndStandby;
        logic [7:0] v;
        repeat (3) pulse(1'b0);
        repeat (2) pulse(1'b1);
        rd(AECP_OFS_CNTLOW, v); `CHK(v, 8'h03)
        rd(AECP_OFS_CNTHIGH, v); `CHK(v, 8'h02)
        // Stopped counters must ignore pin events.
        wr(AECP_OFS_CLKSTOP, 32'hF7);
        pulse(1'b0);
        pulse(1'b1);
        rd(AECP_OFS_CLKSTOP, v); `CHK(v, 8'hF7)
        rd(AECP_OFS_CNTLOW, v); `CHK(v, 8'h03)
        rd(AECP_OFS_CNTHIGH, v); `CHK(v, 8'h02)
    endtask : testPinsAndStandby

    // Runs the counters for a span gated by two standby writes.
    task automatic runSpan(input logic [31:0] ctrl, input int n);
        wr(AECP_OFS_CTRL, ctrl);
        wr(AECP_OFS_CLEAR, 32'h3);
        wr(AECP_OFS_CLKSTOP, 32'hFF);
        repeat (n) @(posedge sys_clk);
        wr(AECP_OFS_CLKSTOP, 32'hF7);
    endtask : runSpan

    task automatic testDividers;
        logic [7:0] v;
        for (int c = 1; c < 4; c++) begin
            runSpan({28'h0, c[1:0], c[1:0]}, 64);
            rd(AECP_OFS_CNTLOW, v);
            `CHK(inRange(v, 64 >> c, (72 >> c) + 1), 1'b1)
            rd(AECP_OFS_CNTHIGH, v);
            `CHK(inRange(v, 64 >> c, (72 >> c) + 1), 1'b1)
        end
    endtask : testDividers

    task automatic testCascadeClear;
        logic [7:0] v;
        runSpan(32'h11, 520);
        rd(AECP_OFS_CNTHIGH, v); `CHK(v, 8'h01)
        rd(AECP_OFS_CNTLOW, v); `CHK(inRange(v, 4, 8), 1'b1)
        wr(AECP_OFS_CLEAR, 32'h1);
        rd(AECP_OFS_CNTLOW, v); `CHK(v, 8'h00)
        rd(AECP_OFS_CNTHIGH, v); `CHK(v, 8'h01)
        wr(AECP_OFS_CLEAR, 32'h2);
        rd(AECP_OFS_CNTHIGH, v); `CHK(v, 8'h00)
        rd(AECP_OFS_CLEAR, v); `CHK(v, 8'h00)
    endtask : testCascadeClear

    // Main sequence: four reset cycles, then every scenario in turn.
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        testReset();
        testPinsAndStandby();
        testDividers();
        testCascadeClear();
        give_verdict();
    end

    // Watchdog well beyond the roughly 930 cycles the scenarios take.
    initial begin
        #800000;
        fails++;
        give_verdict();
    end
endmodule : testbench
